// ===== hw/sfrps_page_stack.sv
`timescale 1ns/1ps
`default_nettype none

module sfrps_page_stack (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST_B,
  input  wire logic                       I_CE,
  input  wire sfrps_pkg::sfrps_acc_type   I_ACC,
  input  wire logic                       I_INT_ENTRY,
  input  wire logic [7:0]                 I_INT_PAGE,
  input  wire logic                       I_INT_RETURN,
  output var  logic [7:0]                 O_RDATA,
  output var  logic                       O_RHIT,
  output var  sfrps_pkg::sfrps_route_type O_ROUTE,
  output var  logic [7:0]                 O_ACTIVE_PAGE,
  output var  logic                       O_AUTO_EN
);

  logic [7:0] active_page_reg;
  logic [7:0] stack_second_reg;
  logic [7:0] stack_third_reg;
  logic       auto_en_reg;
  logic       in_sfr;
  logic       is_all_page;
  logic       ctl_visible;
  logic       do_push;
  logic       do_pop;
  logic       wr_active;
  logic       wr_second;
  logic       wr_third;
  logic       wr_ctl;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  assign in_sfr      = I_ACC.addr >= sfrps_pkg::SFR_BASE;
  assign is_all_page = (I_ACC.addr == sfrps_pkg::ADDR_ACTIVE_PAGE)
                    || (I_ACC.addr == sfrps_pkg::ADDR_STACK_SECOND)
                    || (I_ACC.addr == sfrps_pkg::ADDR_STACK_THIRD);
  assign ctl_visible = (I_ACC.addr == sfrps_pkg::ADDR_PAGE_CONTROL)
                    && (active_page_reg == sfrps_pkg::PAGE_F);
  // stack movement only on core events, never on register access
  assign do_push   = I_INT_ENTRY && auto_en_reg;
  assign do_pop    = I_INT_RETURN && auto_en_reg;
  assign wr_active = I_ACC.wr && I_ACC.addr == sfrps_pkg::ADDR_ACTIVE_PAGE;
  assign wr_second = I_ACC.wr && I_ACC.addr == sfrps_pkg::ADDR_STACK_SECOND;
  assign wr_third  = I_ACC.wr && I_ACC.addr == sfrps_pkg::ADDR_STACK_THIRD;
  assign wr_ctl    = I_ACC.wr && ctl_visible;

  // ----------------------------------------------------------------------
  // page stack; a core event outranks a same-cycle software write
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      active_page_reg <= sfrps_pkg::RST_ACTIVE_PAGE;
    end else if (I_CE) begin
      if (do_push) begin
        active_page_reg <= I_INT_PAGE;
      end else if (do_pop) begin
        active_page_reg <= stack_second_reg;
      end else if (wr_active) begin
        active_page_reg <= I_ACC.wdata;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stack_second_reg <= sfrps_pkg::RST_STACK_SECOND;
    end else if (I_CE) begin
      if (do_push) begin
        stack_second_reg <= active_page_reg;
      end else if (do_pop) begin
        stack_second_reg <= stack_third_reg;
      end else if (wr_second) begin
        stack_second_reg <= I_ACC.wdata;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stack_third_reg <= sfrps_pkg::RST_STACK_THIRD;
    end else if (I_CE) begin
      if (do_push) begin
        stack_third_reg <= stack_second_reg;
      end else if (do_pop) begin
        stack_third_reg <= sfrps_pkg::EMPTY_PAGE;
      end else if (wr_third) begin
        stack_third_reg <= I_ACC.wdata;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      auto_en_reg <=
        sfrps_pkg::RST_PAGE_CONTROL[sfrps_pkg::AUTO_EN_BIT];
    end else if (I_CE && wr_ctl) begin
      auto_en_reg <= I_ACC.wdata[sfrps_pkg::AUTO_EN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // read data and routing, registered one cycle after the request
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= 8'h00;
      O_RHIT  <= 1'b0;
    end else if (I_CE) begin
      O_RHIT  <= I_ACC.rd && (is_all_page || ctl_visible);
      O_RDATA <= 8'h00;
      if (I_ACC.rd) begin
        unique case (1'b1)
          I_ACC.addr == sfrps_pkg::ADDR_ACTIVE_PAGE:  begin
            O_RDATA <= active_page_reg;
          end
          I_ACC.addr == sfrps_pkg::ADDR_STACK_SECOND: begin
            O_RDATA <= stack_second_reg;
          end
          I_ACC.addr == sfrps_pkg::ADDR_STACK_THIRD:  begin
            O_RDATA <= stack_third_reg;
          end
          ctl_visible: begin
            O_RDATA <= {7'h00, auto_en_reg};
          end
          default: begin
            O_RDATA <= 8'h00;
          end
        endcase
      end
    end
  end

  // route for the rest of the sfr space; all-page addresses ignore the page
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ROUTE <= '0;
    end else if (I_CE) begin
      O_ROUTE.offset <= I_ACC.addr;
      O_ROUTE.page   <= active_page_reg;
      O_ROUTE.page_valid <= in_sfr && (is_all_page
        || active_page_reg == sfrps_pkg::PAGE_0
        || active_page_reg == sfrps_pkg::PAGE_1
        || active_page_reg == sfrps_pkg::PAGE_2
        || active_page_reg == sfrps_pkg::PAGE_3
        || active_page_reg == sfrps_pkg::PAGE_F);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ACTIVE_PAGE <= sfrps_pkg::RST_ACTIVE_PAGE;
      O_AUTO_EN     <= sfrps_pkg::RST_PAGE_CONTROL[sfrps_pkg::AUTO_EN_BIT];
    end else if (I_CE) begin
      O_ACTIVE_PAGE <= active_page_reg;
      O_AUTO_EN     <= auto_en_reg;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_push;
    I_CE && do_push;
  endsequence

  sequence s_pop;
    I_CE && do_pop && !do_push;
  endsequence

  a_push_loads_page: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_push |=> active_page_reg == $past(I_INT_PAGE))
    else $error("interrupt page not loaded");
  a_push_moves_down: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_push |=> stack_second_reg == $past(active_page_reg)
           && stack_third_reg == $past(stack_second_reg))
    else $error("push did not shift stack");
  a_pop_moves_up: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_pop |=> active_page_reg == $past(stack_second_reg)
      && stack_second_reg == $past(stack_third_reg)
      && stack_third_reg == sfrps_pkg::EMPTY_PAGE)
    else $error("pop did not shift stack");
  a_disabled_holds: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && !auto_en_reg && !I_ACC.wr |=> $stable(active_page_reg)
      && $stable(stack_second_reg) && $stable(stack_third_reg))
    else $error("stack moved while disabled");
  a_write_no_push: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && wr_second && !I_INT_ENTRY && !I_INT_RETURN
      |=> $stable(active_page_reg) && $stable(stack_third_reg)
      && stack_second_reg == $past(I_ACC.wdata))
    else $error("stack write disturbed other entries");
  a_ctl_on_page_f: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && I_ACC.wr && I_ACC.addr == sfrps_pkg::ADDR_PAGE_CONTROL
      && active_page_reg != sfrps_pkg::PAGE_F |=> $stable(auto_en_reg))
    else $error("control written off page F");
  a_read_active: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && I_ACC.rd && I_ACC.addr == sfrps_pkg::ADDR_ACTIVE_PAGE
      |=> O_RHIT && O_RDATA == $past(active_page_reg))
    else $error("wrong active page read");
  a_route_valid: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && in_sfr && !is_all_page && active_page_reg == 8'h05
      |=> !O_ROUTE.page_valid)
    else $error("unimplemented page routed");
  // a frozen core must not see the stack move under an ignored event
  a_ce_freeze: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    !I_CE |=> $stable(active_page_reg) && $stable(stack_second_reg)
      && $stable(stack_third_reg) && $stable(auto_en_reg)
      && $stable(O_RDATA) && $stable(O_ROUTE))
    else $error("state moved while clock enable low");

endmodule : sfrps_page_stack

`default_nettype wire

// ===== hw/sfrps_pkg.sv
`default_nettype none

package sfrps_pkg;

  // ----------------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ACTIVE_PAGE  = 8'h84;
  localparam logic [7:0] ADDR_STACK_SECOND = 8'h85;
  localparam logic [7:0] ADDR_STACK_THIRD  = 8'h86;
  localparam logic [7:0] ADDR_PAGE_CONTROL = 8'h96;
  localparam logic [7:0] SFR_BASE          = 8'h80;
  localparam logic [7:0] RST_ACTIVE_PAGE   = 8'h00;
  localparam logic [7:0] RST_STACK_SECOND  = 8'h00;
  localparam logic [7:0] RST_STACK_THIRD   = 8'h00;
  localparam logic [7:0] RST_PAGE_CONTROL  = 8'h01;
  localparam int         AUTO_EN_BIT       = 0;
  localparam logic [7:0] EMPTY_PAGE        = 8'h00;

  // ----------------------------------------------------------------------
  // implemented pages
  // ----------------------------------------------------------------------
  localparam logic [7:0] PAGE_0 = 8'h00;
  localparam logic [7:0] PAGE_1 = 8'h01;
  localparam logic [7:0] PAGE_2 = 8'h02;
  localparam logic [7:0] PAGE_3 = 8'h03;
  localparam logic [7:0] PAGE_F = 8'h0F;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrps_acc_type;

  typedef struct packed {
    logic       page_valid;
    logic [7:0] page;
    logic [7:0] offset;
  } sfrps_route_type;

endpackage : sfrps_pkg

`default_nettype wire

// ===== tb/sfrps_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// core and interrupt logic: one-cycle entry and return pulses
// ----------------------------------------------------------------------
module sfrps_cpu_model (
  input  wire logic       i_clk,
  output var  logic       o_entry,
  output var  logic [7:0] o_page,
  output var  logic       o_return
);
  initial begin
    o_entry  = 1'b0;
    o_return = 1'b0;
    o_page   = 8'h00;
  end

  task automatic pulse(input logic ent, input logic [7:0] pg);
    @(posedge i_clk);
    #1;
    o_entry  = ent;
    o_return = ~ent;
    o_page   = pg;
    @(posedge i_clk);
    #1;
    o_entry  = 1'b0;
    o_return = 1'b0;
    // page is only valid with the entry pulse, so do not hold it
    o_page   = ~pg;
  endtask : pulse
endmodule : sfrps_cpu_model

`default_nettype wire

// ===== tb/test_sfr_page_stack.sv
`timescale 1ns/1ps
`default_nettype none

module test_sfr_page_stack;
  logic                       i_clk = 1'b0;
  logic                       i_rst_b;
  sfrps_pkg::sfrps_acc_type   acc;
  sfrps_pkg::sfrps_route_type route;
  logic [7:0]                 rdata, int_page, act_out, ea, e2, e3;
  logic                       rhit, auto_en, ent, ret, en, ce;
  int                         n_mismatch, n_compared, cyc, seed, i, d;

  always #25 i_clk = ~i_clk;

  sfrps_cpu_model cpu (.i_clk(i_clk), .o_entry(ent), .o_page(int_page),
                       .o_return(ret));

  sfrps_page_stack sfrps_page_stack_inst (
    .I_CLK(i_clk), .I_RST_B(i_rst_b), .I_CE(ce), .I_ACC(acc),
    .I_INT_ENTRY(ent), .I_INT_PAGE(int_page), .I_INT_RETURN(ret),
    .O_RDATA(rdata), .O_RHIT(rhit), .O_ROUTE(route),
    .O_ACTIVE_PAGE(act_out), .O_AUTO_EN(auto_en));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    n_compared++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task automatic access(input logic r, input logic [7:0] a,
                        input logic [7:0] w);
    @(posedge i_clk);
    #1;
    acc = '{rd: r, wr: ~r, addr: a, wdata: w};
    @(posedge i_clk);
    #1;
    acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
  endtask : access

  task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] x);
    access(1'b1, a, 8'h00);
    chk("read hit", {7'h00, h}, {7'h00, rhit});
    chk("read data", x, rdata);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    access(1'b0, a, w);
    case (a)
      8'h84: ea = w;
      8'h85: e2 = w;
      8'h86: e3 = w;
      8'h96: if (ea == 8'h0F) en = w[0];
      default: ;
    endcase
  endtask : wr

  // expected push and pop follow the enable bit
  task automatic irq(input logic [7:0] pg);
    cpu.pulse(1'b1, pg);
    if (en) begin
      e3 = e2;
      e2 = ea;
      ea = pg;
    end
  endtask : irq

  task automatic interrupt_return_instr;
    cpu.pulse(1'b0, 8'h00);
    if (en) begin
      ea = e2;
      e2 = e3;
      e3 = 8'h00;
    end
  endtask : interrupt_return_instr

  task automatic stack_chk;
    rd(8'h84, 1'b1, ea);
    rd(8'h85, 1'b1, e2);
    rd(8'h86, 1'b1, e3);
    chk("active out", ea, act_out);
    chk("auto en", {7'h00, en}, {7'h00, auto_en});
  endtask : stack_chk

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  initial begin
    seed = 58;
    acc = '0;
    ce = 1'b1;
    i_rst_b = 1'b0;
    {ea, e2, e3, en} = {24'h000000, 1'b1};
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    stack_chk;
    rd(8'h96, 1'b0, 8'h00);
    wr(8'h84, 8'h0F);
    wr(8'h96, 8'hFF);
    rd(8'h96, 1'b1, 8'h01);
    wr(8'h96, 8'h00);
    irq(8'h02);
    stack_chk;
    interrupt_return_instr;
    stack_chk;
    wr(8'h96, 8'h01);
    irq(8'h02);
    irq(8'h00);
    stack_chk;
    // clock enable low: the entry pulse is never taken
    ce = 1'b0;
    cpu.pulse(1'b1, 8'h01);
    ce = 1'b1;
    stack_chk;
    wr(8'h86, 8'h03);
    interrupt_return_instr;
    interrupt_return_instr;
    stack_chk;
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      case (d[1:0])
        2'd0: irq(d[15:8]);
        2'd1: interrupt_return_instr;
        default: wr(8'h84 + 8'(d[9:8] % 3), d[23:16]);
      endcase
      stack_chk;
    end
    wr(8'h84, 8'h05);
    access(1'b1, 8'h9A, 8'h00);
    chk("route valid", 8'h00, {7'h00, route.page_valid});
    chk("route offset", 8'h9A, route.offset);
    access(1'b1, 8'h84, 8'h00);
    chk("route valid", 8'h01, {7'h00, route.page_valid});
    wr(8'h84, 8'h03);
    access(1'b1, 8'h9A, 8'h00);
    chk("route page", 8'h03, route.page);
    chk("route valid", 8'h01, {7'h00, route.page_valid});
    access(1'b1, 8'h40, 8'h00);
    chk("route valid", 8'h00, {7'h00, route.page_valid});
    // clear the enable, then a mid-run reset must bring it back
    wr(8'h84, 8'h0F);
    wr(8'h96, 8'h00);
    @(posedge i_clk);
    #1;
    i_rst_b = 1'b0;
    @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    {ea, e2, e3, en} = {24'h000000, 1'b1};
    stack_chk;
    wrap_up;
  end
endmodule : test_sfr_page_stack

`default_nettype wire
